/* File: ioc_map.svh */
`ifndef IOC_MAP_SVH
`define IOC_MAP_SVH

// --------------------------------------------------------------
// Register offsets on the plain register port
// --------------------------------------------------------------
`define IOC_OFS_RISE_EN 8'h00
`define IOC_OFS_FALL_EN 8'h01
`define IOC_OFS_FLAGS 8'h02
`define IOC_OFS_INT_CTRL 8'h03
`define IOC_OFS_IRQ_STATUS 8'h04
`define IOC_OFS_IRQ_MASK 8'h05

// --------------------------------------------------------------
// Field positions and reset values
// --------------------------------------------------------------
`define IOC_PIN_HI 7
`define IOC_PIN_LO 4
`define IOC_LOW_ZERO 4'h0
`define IOC_PIN_RST 4'h0
`define IOC_BYTE_ZERO 8'h00
`define IOC_CTRL_IE_BIT 3
`define IOC_CTRL_IF_BIT 0
`define IOC_EVT_FLAG_BIT 0
`define IOC_EVT_WAKE_BIT 1
`define IOC_EVT_RST 2'h0
`define IOC_EVT_PAD 6'h00

`endif

/* File: ioc_pkg.sv */
// --------------------------------------------------------------
// Shared types of the change interrupt block
// --------------------------------------------------------------
package ioc_pkg;

    // One bit per upper pin of the second port
    typedef logic [3:0] pin_vec_t;

    // Interrupt event bits: flag set, wake
    typedef logic [1:0] evt_vec_t;

    // Edge detector state
    typedef struct packed {
        pin_vec_t sync1;
        pin_vec_t sync2;
        pin_vec_t prev;
    } edge_state_t;

    // Register and flag state
    typedef struct packed {
        pin_vec_t rise_en;
        pin_vec_t fall_en;
        pin_vec_t flags;
        logic irq_en;
        evt_vec_t evt_status;
        evt_vec_t evt_mask;
        logic [7:0] rdata;
    } ioc_state_t;

endpackage : ioc_pkg

/* File: ioc_edge_if.sv */
`timescale 1ns/1ns

// --------------------------------------------------------------
// Edge pulses from the detector to the flag logic
// --------------------------------------------------------------
interface ioc_edge_if;
    ioc_pkg::pin_vec_t rise;
    ioc_pkg::pin_vec_t fall;

    modport src (output rise, output fall);
    modport snk (input rise, input fall);
endinterface : ioc_edge_if

/* File: ioc_edge_detect.sv */
`timescale 1ns/1ns
`include "ioc_map.svh"

module ioc_edge_detect (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Pins
    input wire ioc_pkg::pin_vec_t i_second_port_pin,
    // Edge pulses
    ioc_edge_if.src edges
);

    ioc_pkg::edge_state_t q;
    ioc_pkg::edge_state_t d;

    // --------------------------------------------------------------
    // Two-stage synchroniser, then compare with the last sample
    // --------------------------------------------------------------
    always_comb begin
        d = q;
        d.sync1 = i_second_port_pin;
        d.sync2 = q.sync1;
        d.prev = q.sync2;
    end

    // State register
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            q <= '{sync1: `IOC_PIN_RST, sync2: `IOC_PIN_RST, prev: `IOC_PIN_RST};
        end else begin
            q <= d;
        end
    end

    // Pulses last one cycle; sync1 feeds nothing but sync2
    assign edges.rise = q.sync2 & ~q.prev;
    assign edges.fall = ~q.sync2 & q.prev;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    edge_single_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (edges.rise != `IOC_PIN_RST) |=> ((edges.rise & $past(edges.rise)) == `IOC_PIN_RST))
        else $error("rise pulse longer than one cycle");

    edge_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_second_port_pin != q.sync1) |-> ##2 ((edges.rise | edges.fall) != `IOC_PIN_RST))
        else $error("pin change gave no edge pulse");

endmodule : ioc_edge_detect

/* File: port_b_change_interrupt.sv */
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "ioc_map.svh"

// Functional notes
// - Falling edge on a pin counts only when its fall enable bit is one.
// - Enabled rising edge on a pin sets that pin's change flag.
// - Enabled falling edge on a pin sets that pin's change flag.
// - Any enabled edge also sets the summary change flag.
// - Flags set by hardware, read and written by software, stay until cleared.
// - Flag bits are settable by hardware independent of the software write path.
// - Low four bits of enable and flag registers ignore writes, read zero.
// - All enable and flag bits reset to zero on every reset.
// - Summary flag is OR of both ports' flags; interrupt only when enabled.
// - Edge during a clearing write leaves the flag set regardless of data.
// - With interrupt enable set, an enabled edge wakes the device from sleep.

module port_b_change_interrupt (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Pins and neighbouring logic
    input wire ioc_pkg::pin_vec_t i_second_port_pin,
    input wire logic [7:0] i_port_a_change_flags,
    input wire logic i_sleep,
    // Interrupt and wake outputs
    output logic o_summary_change_flag,
    output logic o_change_irq,
    output logic o_wake,
    output logic o_irq
);

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------

    // Address match for one register
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    // Upper pin field of a data byte
    function automatic ioc_pkg::pin_vec_t pins_of(input logic [7:0] data);
        pins_of = data[`IOC_PIN_HI:`IOC_PIN_LO];
    endfunction : pins_of

    // Place a pin field in a byte, low bits read as zero
    function automatic logic [7:0] byte_of(input ioc_pkg::pin_vec_t pins);
        byte_of = {pins, `IOC_LOW_ZERO};
    endfunction : byte_of

    // --------------------------------------------------------------
    // Edge detection
    // --------------------------------------------------------------
    ioc_edge_if edges ();

    ioc_edge_detect u_edge (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_second_port_pin(i_second_port_pin),
        .edges(edges)
    );

    ioc_pkg::ioc_state_t q;
    ioc_pkg::ioc_state_t d;

    // Qualified edges, one cycle each
    ioc_pkg::pin_vec_t rise_set;
    ioc_pkg::pin_vec_t fall_set;
    ioc_pkg::pin_vec_t hw_set;
    logic flag_wr;
    logic summary;
    logic wake_now;
    ioc_pkg::evt_vec_t evt_in;

    // Enables gate each edge kind separately
    assign rise_set = edges.rise & q.rise_en;
    assign fall_set = edges.fall & q.fall_en;
    assign hw_set = rise_set | fall_set;
    assign flag_wr = i_wr && hit(i_addr, `IOC_OFS_FLAGS);

    // Summary covers the first port too, which keeps its own flags
    assign summary = (|q.flags) || (|i_port_a_change_flags);

    // Wake from the stored flags, so they are visible before any fetch
    assign wake_now = i_sleep && q.irq_en && (|q.flags);

    // Events for the interrupt status register
    always_comb begin
        evt_in = `IOC_EVT_RST;
        evt_in[`IOC_EVT_FLAG_BIT] = |hw_set;
        evt_in[`IOC_EVT_WAKE_BIT] = wake_now;
    end

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        d = q;
        // Read data stand only in the cycle after the strobe
        d.rdata = `IOC_BYTE_ZERO;

        // Enable registers; low bits are simply not stored
        if (i_wr && hit(i_addr, `IOC_OFS_RISE_EN)) begin
            d.rise_en = pins_of(i_wdata);
        end
        if (i_wr && hit(i_addr, `IOC_OFS_FALL_EN)) begin
            d.fall_en = pins_of(i_wdata);
        end

        // Flags: software write first, then hardware set on top
        // The set lands last, so an edge during a clearing write is never lost
        if (flag_wr) begin
            d.flags = pins_of(i_wdata);
        end
        d.flags = d.flags | hw_set;

        // Change interrupt enable in the control register
        if (i_wr && hit(i_addr, `IOC_OFS_INT_CTRL)) begin
            d.irq_en = i_wdata[`IOC_CTRL_IE_BIT];
        end

        // Sticky events: write one clears, a new event wins
        if (i_wr && hit(i_addr, `IOC_OFS_IRQ_STATUS)) begin
            d.evt_status = q.evt_status & ~i_wdata[`IOC_EVT_WAKE_BIT:`IOC_EVT_FLAG_BIT];
        end
        d.evt_status = d.evt_status | evt_in;

        if (i_wr && hit(i_addr, `IOC_OFS_IRQ_MASK)) begin
            d.evt_mask = i_wdata[`IOC_EVT_WAKE_BIT:`IOC_EVT_FLAG_BIT];
        end

        // Read mux; unmapped addresses read zero
        // Reads have no side effect: flags only clear by an explicit write
        if (i_rd) begin
            case (i_addr)
                `IOC_OFS_RISE_EN: begin
                    d.rdata = byte_of(q.rise_en);
                end
                `IOC_OFS_FALL_EN: begin
                    d.rdata = byte_of(q.fall_en);
                end
                `IOC_OFS_FLAGS: begin
                    d.rdata = byte_of(q.flags);
                end
                `IOC_OFS_INT_CTRL: begin
                    d.rdata[`IOC_CTRL_IE_BIT] = q.irq_en;
                    d.rdata[`IOC_CTRL_IF_BIT] = summary;
                end
                `IOC_OFS_IRQ_STATUS: begin
                    d.rdata = {`IOC_EVT_PAD, q.evt_status};
                end
                `IOC_OFS_IRQ_MASK: begin
                    d.rdata = {`IOC_EVT_PAD, q.evt_mask};
                end
                default: begin
                    d.rdata = `IOC_BYTE_ZERO;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------

    // Every reset source clears all enables and flags
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            q <= '{rise_en: `IOC_PIN_RST, fall_en: `IOC_PIN_RST, flags: `IOC_PIN_RST,
                   irq_en: 1'b0, evt_status: `IOC_EVT_RST, evt_mask: `IOC_EVT_RST,
                   rdata: `IOC_BYTE_ZERO};
        end else begin
            q <= d;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------

    // Summary and gated change interrupt
    assign o_rdata = q.rdata;
    assign o_summary_change_flag = summary;
    assign o_change_irq = summary && q.irq_en;
    assign o_wake = wake_now;
    assign o_irq = |(q.evt_status & q.evt_mask);

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    fall_mask_a: assert property (
        (!flag_wr && (edges.rise == `IOC_PIN_RST))
        |=> (q.flags == ($past(q.flags) | $past(edges.fall & q.fall_en))))
        else $error("flag change not matching fall enables");

    rise_sets_a: assert property (
        (rise_set != `IOC_PIN_RST) |=> ((q.flags & $past(rise_set)) == $past(rise_set)))
        else $error("enabled rising edge did not set flag");

    fall_sets_a: assert property (
        (fall_set != `IOC_PIN_RST) |=> ((q.flags & $past(fall_set)) == $past(fall_set)))
        else $error("enabled falling edge did not set flag");

    summary_set_a: assert property (
        (hw_set != `IOC_PIN_RST) |=> o_summary_change_flag)
        else $error("summary flag missing after enabled edge");

    flag_hold_a: assert property (
        (!flag_wr && (hw_set == `IOC_PIN_RST)) ##1 (!flag_wr && (hw_set == `IOC_PIN_RST))
        |=> (q.flags == $past(q.flags, 2)))
        else $error("flag changed without write or edge");

    set_wins_a: assert property (
        (flag_wr && (hw_set != `IOC_PIN_RST)) |=> ((q.flags & $past(hw_set)) == $past(hw_set)))
        else $error("clearing write lost a new edge");

    write_clear_a: assert property (
        (flag_wr && (hw_set == `IOC_PIN_RST)) |=> (q.flags == pins_of($past(i_wdata))))
        else $error("flag write not stored");

    low_zero_a: assert property (
        (i_rd && (hit(i_addr, `IOC_OFS_FLAGS) || hit(i_addr, `IOC_OFS_RISE_EN)
            || hit(i_addr, `IOC_OFS_FALL_EN)))
        |=> (o_rdata[`IOC_PIN_LO - 1:0] == `IOC_LOW_ZERO))
        else $error("low bits read non-zero");

    reset_zero_a: assert property (@(posedge i_clk_sys) disable iff (1'b0)
        (!i_nrst) |=> ((q.flags == `IOC_PIN_RST) && (q.rise_en == `IOC_PIN_RST)
            && (q.fall_en == `IOC_PIN_RST)))
        else $error("state not cleared by reset");

    irq_gate_a: assert property (
        (!q.irq_en) |-> (!o_change_irq && (o_summary_change_flag == ((|q.flags) || (|i_port_a_change_flags)))))
        else $error("change interrupt without enable");

    wake_edge_a: assert property (
        (i_sleep && q.irq_en && (hw_set != `IOC_PIN_RST) && !(i_wr && hit(i_addr, `IOC_OFS_INT_CTRL)))
        ##1 i_sleep |-> o_wake)
        else $error("enabled edge did not wake");

    read_late_a: assert property (
        (!i_rd) |=> (o_rdata == `IOC_BYTE_ZERO))
        else $error("read data outside read slot");

    // --------------------------------------------------------------
    // Register port checks
    // --------------------------------------------------------------

    // Enable stores keep only the upper pin field; control keeps bit 3, mask the two event bits
    rise_store_a: assert property (
        (i_wr && hit(i_addr, `IOC_OFS_RISE_EN)) |=> (q.rise_en == pins_of($past(i_wdata))))
        else $error("rise enable write not stored");

    fall_store_a: assert property (
        (i_wr && hit(i_addr, `IOC_OFS_FALL_EN)) |=> (q.fall_en == pins_of($past(i_wdata))))
        else $error("fall enable write not stored");

    ctrl_store_a: assert property (
        (i_wr && hit(i_addr, `IOC_OFS_INT_CTRL)) |=> (q.irq_en == $past(i_wdata[`IOC_CTRL_IE_BIT])))
        else $error("change interrupt enable not stored");

    mask_store_a: assert property (
        (i_wr && hit(i_addr, `IOC_OFS_IRQ_MASK))
        |=> (q.evt_mask == $past(i_wdata[`IOC_EVT_WAKE_BIT:`IOC_EVT_FLAG_BIT])))
        else $error("event mask write not stored");

    // Reads return the state as it stood in the strobe cycle
    flags_read_a: assert property (
        (i_rd && hit(i_addr, `IOC_OFS_FLAGS)) |=> (o_rdata == byte_of($past(q.flags))))
        else $error("flag read does not match stored flags");

    ctrl_read_a: assert property (
        (i_rd && hit(i_addr, `IOC_OFS_INT_CTRL)) |=> (o_rdata[`IOC_CTRL_IF_BIT] == $past(summary)))
        else $error("summary bit read wrong");

    // Unmapped addresses read zero, so software sees no stale byte
    unmapped_read_a: assert property (
        (i_rd && (i_addr > `IOC_OFS_IRQ_MASK)) |=> (o_rdata == `IOC_BYTE_ZERO))
        else $error("unmapped address read non-zero");

    // --------------------------------------------------------------
    // Flag, summary and wake checks
    // --------------------------------------------------------------

    // Outside a flag write, a new flag bit may only come from an enabled edge
    stray_flag_a: assert property (
        (!flag_wr) |=> ((q.flags & ~$past(q.flags) & ~$past(hw_set)) == `IOC_PIN_RST))
        else $error("flag set without an enabled edge");

    summary_or_a: assert property (
        ((|q.flags) || (|i_port_a_change_flags)) |-> o_summary_change_flag)
        else $error("summary flag misses a set flag");

    irq_follow_a: assert property (
        (q.irq_en && o_summary_change_flag) |-> o_change_irq)
        else $error("enabled change interrupt not raised");

    wake_gate_a: assert property (
        (!i_sleep || !q.irq_en) |-> !o_wake)
        else $error("wake without sleep and enable");

    // --------------------------------------------------------------
    // Event status checks
    // --------------------------------------------------------------

    evt_flag_a: assert property (
        (hw_set != `IOC_PIN_RST) |=> q.evt_status[`IOC_EVT_FLAG_BIT])
        else $error("flag event not recorded");

    wake_evt_a: assert property (
        o_wake |=> q.evt_status[`IOC_EVT_WAKE_BIT])
        else $error("wake event not recorded");

    // Write one clears; checked only when no event arrives on the same edge
    evt_clear_a: assert property (
        (i_wr && hit(i_addr, `IOC_OFS_IRQ_STATUS) && (evt_in == `IOC_EVT_RST))
        |=> ((q.evt_status & $past(i_wdata[`IOC_EVT_WAKE_BIT:`IOC_EVT_FLAG_BIT])) == `IOC_EVT_RST))
        else $error("event status not cleared by write");

    evt_hold_a: assert property (
        (q.evt_status[`IOC_EVT_FLAG_BIT] && !(i_wr && hit(i_addr, `IOC_OFS_IRQ_STATUS)))
        |=> q.evt_status[`IOC_EVT_FLAG_BIT])
        else $error("flag event dropped without a write");

    irq_quiet_a: assert property (
        ((q.evt_status & q.evt_mask) == `IOC_EVT_RST) |-> !o_irq)
        else $error("event interrupt with nothing pending");

    // --------------------------------------------------------------
    // Reset checks
    // --------------------------------------------------------------

    // Checked with reset in force, so the default disable is switched off here
    reset_ctrl_a: assert property (@(posedge i_clk_sys) disable iff (1'b0)
        (!i_nrst) |=> (!q.irq_en && (q.evt_status == `IOC_EVT_RST) && (q.evt_mask == `IOC_EVT_RST)))
        else $error("control state not cleared by reset");

endmodule : port_b_change_interrupt

/* File: pin_drive_model.sv */
`timescale 1ns/1ns

// --------------------------------------------------------------
// Far-side model: the four upper pins of the second port
// --------------------------------------------------------------
module pin_drive_model (
    // Clock
    input wire logic i_clk_sys,
    // Levels requested by the test sequence
    input wire ioc_pkg::pin_vec_t i_level,
    // Pin levels seen by the block
    output ioc_pkg::pin_vec_t o_pin
);
    // Pins move one edge after the request, so each edge lands on a known cycle
    always_ff @(posedge i_clk_sys) begin
        o_pin <= i_level;
    end
endmodule : pin_drive_model

/* File: testbench.sv */
`timescale 1ns/1ns
`include "ioc_map.svh"

module testbench;
    logic i_clk_sys;
    logic i_nrst;
    logic [7:0] i_addr;
    logic [7:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [7:0] o_rdata;
    ioc_pkg::pin_vec_t pin_level;
    ioc_pkg::pin_vec_t pins;
    logic [7:0] i_port_a_change_flags;
    logic i_sleep;
    logic o_summary_change_flag;
    logic o_change_irq;
    logic o_wake;
    logic o_irq;
    logic [7:0] seen;
    int failures;
    int n_checks;
    // Level outputs side by side, so the compare task can pick one after its edge
    logic [3:0] levels;
    localparam int LVL_SUMMARY = 0;
    localparam int LVL_CHANGE = 1;
    localparam int LVL_WAKE = 2;
    localparam int LVL_IRQ = 3;

    assign levels = {o_irq, o_wake, o_change_irq, o_summary_change_flag};

    pin_drive_model pin_model (.i_clk_sys(i_clk_sys), .i_level(pin_level), .o_pin(pins));

    port_b_change_interrupt dut (
        .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_second_port_pin(pins),
        .i_port_a_change_flags(i_port_a_change_flags), .i_sleep(i_sleep),
        .o_summary_change_flag(o_summary_change_flag), .o_change_irq(o_change_irq),
        .o_wake(o_wake), .o_irq(o_irq)
    );

    // --------------------------------------------------------------
    // Clock and hang guard
    // --------------------------------------------------------------
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // A hung sequence counts as a mismatch and still reaches the report
    initial begin
        repeat (5000) @(posedge i_clk_sys);
        failures++;
        complete_run();
    end

    // --------------------------------------------------------------
    // Access tasks and comparisons
    // --------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Write is one strobe cycle, then a cycle with the strobe low
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clk_sys);
        i_addr <= addr;
        i_wdata <= data;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge i_clk_sys);
        i_addr <= addr;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        data = o_rdata;
    endtask : rd

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] got;
        rd(addr, got);
        check(got, exp);
    endtask : rd_chk

    // Level outputs are picked only once the edge's updates have landed, never at call time
    task automatic lvl_chk(input int idx, input logic exp);
        @(posedge i_clk_sys);
        #1;
        check({7'h00, levels[idx]}, {7'h00, exp});
    endtask : lvl_chk

    // Sync, edge pulse and flag need a few edges after the pin moves
    task automatic set_pins(input ioc_pkg::pin_vec_t v);
        @(posedge i_clk_sys);
        pin_level <= v;
        repeat (6) @(posedge i_clk_sys);
    endtask : set_pins

    task automatic complete_run;
        $display("Checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        i_nrst = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        pin_level = 4'h0;
        i_port_a_change_flags = 8'h00;
        i_sleep = 1'b0;
        failures = 0;
        n_checks = 0;
        repeat (10) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        // Reset values, unmapped address
        for (int a = 0; a < 6; a++) rd_chk(a[7:0], 8'h00);
        rd_chk(8'h10, 8'h00);
        lvl_chk(LVL_IRQ, 1'b0);
        // Low nibble ignores writes
        wr(`IOC_OFS_RISE_EN, 8'hFF);
        rd_chk(`IOC_OFS_RISE_EN, 8'hF0);
        wr(`IOC_OFS_FALL_EN, 8'h0F);
        rd_chk(`IOC_OFS_FALL_EN, 8'h00);
        wr(`IOC_OFS_FLAGS, 8'h0F);
        rd_chk(`IOC_OFS_FLAGS, 8'h00);
        // Rising edges with enable set, interrupt enable still off
        set_pins(4'hF);
        rd_chk(`IOC_OFS_FLAGS, 8'hF0);
        lvl_chk(LVL_SUMMARY, 1'b1);
        lvl_chk(LVL_CHANGE, 1'b0);
        rd_chk(`IOC_OFS_INT_CTRL, 8'h01);
        // Clear only bits already seen, by AND masking
        rd(`IOC_OFS_FLAGS, seen);
        wr(`IOC_OFS_FLAGS, seen & 8'hCF);
        rd_chk(`IOC_OFS_FLAGS, 8'hC0);
        wr(`IOC_OFS_FLAGS, 8'h50);
        rd_chk(`IOC_OFS_FLAGS, 8'h50);
        wr(`IOC_OFS_FLAGS, 8'h00);
        rd_chk(`IOC_OFS_FLAGS, 8'h00);
        // Falling edges with fall enable off, then on for pins 7 and 5
        set_pins(4'h0);
        rd_chk(`IOC_OFS_FLAGS, 8'h00);
        wr(`IOC_OFS_RISE_EN, 8'h00);
        wr(`IOC_OFS_FALL_EN, 8'hA0);
        set_pins(4'hF);
        rd_chk(`IOC_OFS_FLAGS, 8'h00);
        set_pins(4'h0);
        rd_chk(`IOC_OFS_FLAGS, 8'hA0);
        // Interrupt enable, wake from sleep
        wr(`IOC_OFS_INT_CTRL, 8'hFF);
        rd_chk(`IOC_OFS_INT_CTRL, 8'h09);
        lvl_chk(LVL_CHANGE, 1'b1);
        i_sleep <= 1'b1;
        lvl_chk(LVL_WAKE, 1'b1);
        wr(`IOC_OFS_FLAGS, 8'h00);
        lvl_chk(LVL_WAKE, 1'b0);
        lvl_chk(LVL_CHANGE, 1'b0);
        i_sleep <= 1'b0;
        // First-port flags reach the summary
        i_port_a_change_flags <= 8'h04;
        lvl_chk(LVL_SUMMARY, 1'b1);
        lvl_chk(LVL_CHANGE, 1'b1);
        i_port_a_change_flags <= 8'h00;
        // Event status, mask and level interrupt; the wake above left its event
        rd_chk(`IOC_OFS_IRQ_STATUS, 8'h03);
        wr(`IOC_OFS_IRQ_STATUS, 8'h03);
        wr(`IOC_OFS_IRQ_MASK, 8'hFF);
        rd_chk(`IOC_OFS_IRQ_MASK, 8'h03);
        lvl_chk(LVL_IRQ, 1'b0);
        wr(`IOC_OFS_FALL_EN, 8'h00);
        wr(`IOC_OFS_RISE_EN, 8'h10);
        set_pins(4'h1);
        lvl_chk(LVL_IRQ, 1'b1);
        rd_chk(`IOC_OFS_IRQ_STATUS, 8'h01);
        wr(`IOC_OFS_IRQ_STATUS, 8'h01);
        lvl_chk(LVL_IRQ, 1'b0);
        // Edge landing on the same edge as a clearing write
        wr(`IOC_OFS_FLAGS, 8'h00);
        set_pins(4'h0);
        wr(`IOC_OFS_RISE_EN, 8'hF0);
        @(posedge i_clk_sys);
        pin_level <= 4'hF;
        repeat (2) @(posedge i_clk_sys);
        wr(`IOC_OFS_FLAGS, 8'h00);
        rd_chk(`IOC_OFS_FLAGS, 8'hF0);
        // Second reset in mid-run
        @(posedge i_clk_sys);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        rd_chk(`IOC_OFS_RISE_EN, 8'h00);
        rd_chk(`IOC_OFS_FLAGS, 8'h00);
        rd_chk(`IOC_OFS_INT_CTRL, 8'h00);
        complete_run();
    end
endmodule : testbench
